// ==== sample_packer_pkg.sv ====
// constants, types and parameter tables for the lane sample packer
package sample_packer_pkg;
    localparam int SAMPLE_W = 14;
    localparam int OCTET_W = 8;
    localparam int MAX_LANES = 3;
    localparam int SIMPLE_LANES = 2;
    localparam int MAX_SAMPLES = 12;
    localparam int SAMPLES_PER_LANE = 4;
    localparam int TAIL_W = 2;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_FRAMECNT = 8'h02;
    localparam logic [7:0] ADDR_PARAM_F = 8'h10;
    localparam logic [7:0] ADDR_PARAM_L = 8'h11;
    localparam logic [7:0] ADDR_PARAM_M = 8'h12;
    localparam logic [7:0] ADDR_PARAM_N = 8'h13;
    localparam logic [7:0] ADDR_PARAM_NP = 8'h14;
    localparam logic [7:0] ADDR_PARAM_S = 8'h15;
    localparam logic [7:0] ADDR_PARAM_K = 8'h16;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int STATUS_UNDERRUN_BIT = 0;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic UNDERRUN_RESET = 1'b0;

    typedef enum logic [1:0] {
        MODE_EFF3 = 2'b00,
        MODE_EFF2 = 2'b01,
        MODE_SIMPLE = 2'b10,
        MODE_RSVD = 2'b11
    } pack_mode_t;

    localparam pack_mode_t MODE_RESET = MODE_EFF3;

    // every field holds its value minus one
    typedef struct packed {
        logic [4:0] f;
        logic [4:0] l;
        logic [4:0] m;
        logic [4:0] n;
        logic [4:0] np;
        logic [4:0] s;
        logic [4:0] k;
    } link_param_t;

    localparam link_param_t PARAM_EFF3 = '{f: 5'h06, l: 5'h02, m: 5'h00,
        n: 5'h0d, np: 5'h0d, s: 5'h0b, k: 5'h02};
    localparam link_param_t PARAM_EFF2 = '{f: 5'h06, l: 5'h01, m: 5'h00,
        n: 5'h0d, np: 5'h0d, s: 5'h07, k: 5'h02};
    localparam link_param_t PARAM_SIMPLE = '{f: 5'h01, l: 5'h01, m: 5'h01,
        n: 5'h0d, np: 5'h0f, s: 5'h00, k: 5'h08};
    localparam link_param_t PARAM_RESET = PARAM_EFF3;

    function automatic link_param_t modeParams(input pack_mode_t mode);
        case (mode)
            MODE_EFF2: modeParams = PARAM_EFF2;
            MODE_SIMPLE: modeParams = PARAM_SIMPLE;
            default: modeParams = PARAM_EFF3;
        endcase
    endfunction
endpackage

// ==== lane_map_if.sv ====
// frame samples and lane octets between packer and octet mapper
`timescale 1ns/1ps
interface lane_map_if;
    import sample_packer_pkg::*;
    logic [SAMPLE_W-1:0] frameSample [MAX_SAMPLES];
    logic [2:0] octIdx;
    logic simpleMode;
    logic [OCTET_W-1:0] laneOctet [MAX_LANES];
    modport packer (
        output frameSample,
        output octIdx,
        output simpleMode,
        input laneOctet
    );
    modport mapper (
        input frameSample,
        input octIdx,
        input simpleMode,
        output laneOctet
    );
endinterface

// ==== lane_octet_mapper.sv ====
// slices one frame of samples into the current octet of each lane
`timescale 1ns/1ps
module lane_octet_mapper
    import sample_packer_pkg::*;
(
    lane_map_if.mapper mapBus
);
    // four samples back to back, msb first, octet idx taken from the top
    function automatic logic [7:0] effOctet(
        input logic [13:0] s0,
        input logic [13:0] s1,
        input logic [13:0] s2,
        input logic [13:0] s3,
        input logic [2:0] idx
    );
        logic [55:0] word;
        word = {s0, s1, s2, s3} << {idx, 3'b000};
        effOctet = word[55:48];
    endfunction

    // 16-bit slot: sample then zero tail bits
    function automatic logic [7:0] simpleOctet(
        input logic [13:0] s,
        input logic idx
    );
        logic [15:0] slot;
        slot = {s, {TAIL_W{1'b0}}};
        simpleOctet = idx ? slot[7:0] : slot[15:8];
    endfunction

    for (genvar l = 0; l < MAX_LANES; l++) begin : g_lane
        always_comb begin
            if (mapBus.simpleMode) begin
                // converter stream l on lane l, tails zero
                mapBus.laneOctet[l] = (l < SIMPLE_LANES) ?
                    simpleOctet(mapBus.frameSample[l], mapBus.octIdx[0]) :
                    8'h00;
            end else begin
                // samples 4l..4l+3 on lane l
                mapBus.laneOctet[l] = effOctet(
                    mapBus.frameSample[SAMPLES_PER_LANE*l],
                    mapBus.frameSample[SAMPLES_PER_LANE*l+1],
                    mapBus.frameSample[SAMPLES_PER_LANE*l+2],
                    mapBus.frameSample[SAMPLES_PER_LANE*l+3],
                    mapBus.octIdx);
            end
        end
    end
endmodule

// ==== serial_lane_sample_packer.sv ====
// transport packer: converter samples into frames of octets on 2 or 3 lanes
//
// Behaviour
// - efficient: 14-bit, no tails, 7 octets, 12 samples/3 lanes or 8/2.
// - simple: 2 lanes, two streams, 2 octets, 16-bit slot, K at least 9.
// - link parameters are kept encoded as value minus one.
// - efficient lane frame packs 4 samples msb first into 7 octets.
// - earliest samples on the first lane, later groups on later lanes.
// - simple: stream 0 on first lane, stream 1 on second lane.
`timescale 1ns/1ps
module serial_lane_sample_packer
    import sample_packer_pkg::*;
(
    input logic ref_clk,
    input logic sys_rst,
    input logic [7:0] regAddr,
    input logic [7:0] regWrData,
    input logic regWrEn,
    input logic regRdEn,
    output logic [7:0] regRdData,
    input logic [13:0] sampleEven,
    input logic [13:0] sampleOdd,
    input logic sampleValid,
    output logic sampleReady,
    output logic [7:0] firstLaneOctet,
    output logic [7:0] secondLaneOctet,
    output logic [7:0] thirdLaneOctet,
    output logic octetValid,
    output logic frameStart,
    output logic multiframeEnd
);
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } pack_state_t;

    pack_state_t state_reg;
    pack_state_t state_next;
    logic enable_reg;
    pack_mode_t mode_reg;
    link_param_t param_reg;
    logic underrun_reg;
    logic [4:0] frameCnt_reg;
    logic [2:0] octIdx_reg;
    logic [2:0] beatCnt_reg;
    logic [13:0] collect_reg [MAX_SAMPLES];
    logic [13:0] frame_reg [MAX_SAMPLES];
    logic [7:0] lane_reg [MAX_LANES];
    logic octetValid_reg;
    logic frameStart_reg;
    logic mfEnd_reg;
    logic [7:0] rdData_reg;

    logic [2:0] fLast;
    logic [2:0] beatTarget;
    logic [1:0] laneLast;
    logic simpleMode;
    logic running;
    logic bufFull;
    logic frameLoad;
    logic beatTake;
    logic underrunEvent;
    logic ctrlWrite;
    link_param_t modeTable;
    pack_mode_t modeReq;

    lane_map_if mapBus();

    lane_octet_mapper mapperInst (
        .mapBus(mapBus)
    );

    // input beats per frame: samples times streams over two per beat
    function automatic logic [2:0] beatsPerFrame(input link_param_t p);
        logic [9:0] prod;
        prod = 10'((p.s + 10'h1) * (p.m + 10'h1));
        beatsPerFrame = prod[3:1];
    endfunction

    assign fLast = param_reg.f[2:0];
    assign laneLast = param_reg.l[1:0];
    assign beatTarget = beatsPerFrame(param_reg);
    assign simpleMode = (mode_reg == MODE_SIMPLE);
    assign running = (state_reg == ST_RUN);
    assign bufFull = (beatCnt_reg == beatTarget);
    assign frameLoad = enable_reg && (octIdx_reg == fLast);
    assign sampleReady = enable_reg && (beatCnt_reg < beatTarget);
    assign beatTake = sampleValid && sampleReady;
    assign underrunEvent = frameLoad && running && !bufFull;
    assign ctrlWrite = regWrEn && (regAddr == ADDR_CTRL);
    assign modeReq = pack_mode_t'(regWrData[CTRL_MODE_LSB +: 2]);
    assign modeTable = modeParams(mode_reg);

    assign mapBus.octIdx = octIdx_reg;
    assign mapBus.simpleMode = simpleMode;
    for (genvar i = 0; i < MAX_SAMPLES; i++) begin : g_frame
        assign mapBus.frameSample[i] = frame_reg[i];
    end

    // control register and parameter table
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            enable_reg <= ENABLE_RESET;
            mode_reg <= MODE_RESET;
            param_reg <= PARAM_RESET;
        end else if (ctrlWrite) begin
            enable_reg <= regWrData[CTRL_ENABLE_BIT];
            // mode only changes while stopped; reserved code ignored
            if (!enable_reg && modeReq != MODE_RSVD) begin
                mode_reg <= modeReq;
                param_reg <= modeParams(modeReq);
            end
        end else if (regWrEn && regAddr == ADDR_PARAM_K && !enable_reg) begin
            // multiframe length clamped to the mode's least
            if (regWrData[4:0] < modeTable.k) begin
                param_reg.k <= modeTable.k;
            end else begin
                param_reg.k <= regWrData[4:0];
            end
        end
    end

    // run state
    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = enable_reg ? ST_RUN : ST_IDLE;
            ST_RUN: state_next = enable_reg ? ST_RUN : ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // octet position within the frame, frames back to back
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            octIdx_reg <= PARAM_RESET.f[2:0];
        end else if (!enable_reg) begin
            octIdx_reg <= fLast;
        end else if (frameLoad) begin
            octIdx_reg <= 3'h0;
        end else begin
            octIdx_reg <= octIdx_reg + 3'h1;
        end
    end

    // frames within the multiframe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frameCnt_reg <= 5'h00;
        end else if (!enable_reg) begin
            frameCnt_reg <= 5'h00;
        end else if (frameLoad && running) begin
            if (frameCnt_reg == param_reg.k) begin
                frameCnt_reg <= 5'h00;
            end else begin
                frameCnt_reg <= frameCnt_reg + 5'h01;
            end
        end
    end

    // beat count of the collecting buffer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            beatCnt_reg <= 3'h0;
        end else if (!enable_reg) begin
            beatCnt_reg <= 3'h0;
        end else if (frameLoad && bufFull) begin
            beatCnt_reg <= 3'h0;
        end else if (beatTake) begin
            beatCnt_reg <= beatCnt_reg + 3'h1;
        end
    end

    // even slot takes the earlier sample or stream 0
    for (genvar i = 0; i < MAX_SAMPLES; i++) begin : g_slot
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                collect_reg[i] <= 14'h0000;
            end else if (beatTake && beatCnt_reg == 3'(i / 2)) begin
                collect_reg[i] <= (i % 2 == 1) ? sampleOdd : sampleEven;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                frame_reg[i] <= 14'h0000;
            end else if (frameLoad) begin
                frame_reg[i] <= bufFull ? collect_reg[i] : 14'h0000;
            end
        end
    end

    // lane outputs, all lanes on one octet boundary
    for (genvar l = 0; l < MAX_LANES; l++) begin : g_out
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                lane_reg[l] <= 8'h00;
            end else if (running && 2'(l) <= laneLast) begin
                lane_reg[l] <= mapBus.laneOctet[l];
            end else begin
                lane_reg[l] <= 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            octetValid_reg <= 1'b0;
            frameStart_reg <= 1'b0;
            mfEnd_reg <= 1'b0;
        end else begin
            octetValid_reg <= running;
            frameStart_reg <= running && octIdx_reg == 3'h0;
            mfEnd_reg <= running && octIdx_reg == fLast &&
                frameCnt_reg == param_reg.k;
        end
    end

    // sticky underrun, set wins over write-one clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            underrun_reg <= UNDERRUN_RESET;
        end else if (underrunEvent) begin
            underrun_reg <= 1'b1;
        end else if (regWrEn && regAddr == ADDR_STATUS &&
                regWrData[STATUS_UNDERRUN_BIT]) begin
            underrun_reg <= 1'b0;
        end
    end

    // read data, one cycle after the strobe, zero elsewhere
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !regRdEn) begin
            rdData_reg <= 8'h00;
        end else begin
            case (regAddr)
                ADDR_CTRL: rdData_reg <= {5'h00, mode_reg, enable_reg};
                ADDR_STATUS: rdData_reg <= {6'h00, running, underrun_reg};
                ADDR_FRAMECNT: rdData_reg <= {3'h0, frameCnt_reg};
                ADDR_PARAM_F: rdData_reg <= {3'h0, param_reg.f};
                ADDR_PARAM_L: rdData_reg <= {3'h0, param_reg.l};
                ADDR_PARAM_M: rdData_reg <= {3'h0, param_reg.m};
                ADDR_PARAM_N: rdData_reg <= {3'h0, param_reg.n};
                ADDR_PARAM_NP: rdData_reg <= {3'h0, param_reg.np};
                ADDR_PARAM_S: rdData_reg <= {3'h0, param_reg.s};
                ADDR_PARAM_K: rdData_reg <= {3'h0, param_reg.k};
                default: rdData_reg <= 8'h00;
            endcase
        end
    end

    assign regRdData = rdData_reg;
    assign firstLaneOctet = lane_reg[0];
    assign secondLaneOctet = lane_reg[1];
    assign thirdLaneOctet = lane_reg[2];
    assign octetValid = octetValid_reg;
    assign frameStart = frameStart_reg;
    assign multiframeEnd = mfEnd_reg;

    // helper: cycles between frame starts while enable holds
    logic [3:0] gapCnt;
    logic gapValid;
    logic enPrev;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gapCnt <= 4'h0;
            gapValid <= 1'b0;
            enPrev <= 1'b0;
        end else begin
            enPrev <= enable_reg;
            if (frameStart_reg) begin
                gapCnt <= 4'h0;
                gapValid <= enable_reg && enPrev;
            end else begin
                if (gapCnt != 4'hf) begin
                    gapCnt <= gapCnt + 4'h1;
                end
                if (!enable_reg) begin
                    gapValid <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    eff_gap_a: assert property (
        (frameStart_reg && gapValid && !simpleMode) |-> gapCnt == 4'h6)
        else $error("efficient frame not seven octets");
    simple_gap_a: assert property (
        (frameStart_reg && gapValid && simpleMode) |-> gapCnt == 4'h1)
        else $error("simple frame not two octets");
    encoded_param_a: assert property (
        param_reg.f == modeTable.f && param_reg.s == modeTable.s &&
        param_reg.k >= modeTable.k && (simpleMode ?
        (param_reg.f == 5'h01 && param_reg.np == 5'h0f) :
        (param_reg.f == 5'h06 && param_reg.np == 5'h0d)))
        else $error("encoded parameters disagree with mode");
    lane_order_a: assert property (
        (running && octIdx_reg == 3'h0 && !simpleMode) |=>
        firstLaneOctet == $past(frame_reg[0][13:6]) &&
        secondLaneOctet == $past(frame_reg[4][13:6]))
        else $error("efficient lane order wrong");
    mid_octet_a: assert property (
        (running && octIdx_reg == 3'h3 && !simpleMode) |=>
        firstLaneOctet ==
        {$past(frame_reg[1][3:0]), $past(frame_reg[2][13:10])})
        else $error("fourth octet packing wrong");
    last_octet_a: assert property (
        (running && octIdx_reg == 3'h6 && !simpleMode) |=>
        firstLaneOctet == $past(frame_reg[3][7:0]))
        else $error("last octet packing wrong");
    simple_lane_a: assert property (
        (running && octIdx_reg == 3'h1 && simpleMode) |=>
        secondLaneOctet == {$past(frame_reg[1][5:0]), 2'b00})
        else $error("second stream octet wrong");
    tail_zero_a: assert property (
        ($past(simpleMode) && octetValid_reg && !frameStart_reg) |->
        firstLaneOctet[1:0] == 2'b00 && secondLaneOctet[1:0] == 2'b00 &&
        thirdLaneOctet == 8'h00)
        else $error("tail bits or idle lane not zero");
    underrun_set_a: assert property (
        underrunEvent |=> underrun_reg)
        else $error("underrun flag lost");
endmodule

// ==== lane_receiver_model.sv ====
// receiving end model: gathers lane octets back into whole frames
`timescale 1ns/1ps
module lane_receiver_model
    import sample_packer_pkg::*;
(
    input logic ref_clk,
    input logic [7:0] firstLane,
    input logic [7:0] secondLane,
    input logic [7:0] thirdLane,
    input logic octetValid,
    input logic frameStart,
    input logic multiframeEnd,
    input logic [3:0] frameLen,
    output logic [55:0] laneBits [MAX_LANES],
    output logic frameDone,
    output int mfLen,
    output int misalign
);
    logic [55:0] sh [MAX_LANES];
    logic [7:0] oct [MAX_LANES];
    int cnt = 0;
    int mfCnt = 0;
    assign oct[0] = firstLane;
    assign oct[1] = secondLane;
    assign oct[2] = thirdLane;
    initial begin
        frameDone = 1'b0;
        mfLen = 0;
        misalign = 0;
    end
    always @(posedge ref_clk) begin
        frameDone <= 1'b0;
        if (octetValid !== 1'b1) begin
            cnt = 0;
            mfCnt = 0;
        end else begin
            // frames back to back, each opened by its start mark
            if (frameStart !== (cnt == 0 || cnt == frameLen)) misalign++;
            if (frameStart === 1'b1) cnt = 0;
            cnt++;
            // msb first, earliest samples on first lane
            for (int l = 0; l < MAX_LANES; l++) begin
                sh[l] = (cnt == 1) ? {48'h0, oct[l]} : {sh[l][47:0], oct[l]};
            end
            if (cnt == frameLen) begin
                laneBits <= sh;
                frameDone <= 1'b1;
                mfCnt++;
            end
            // multiframe closes on a frame's last octet
            if (multiframeEnd === 1'b1) begin
                if (cnt != frameLen) misalign++;
                mfLen <= mfCnt;
                mfCnt = 0;
            end
        end
    end
endmodule

// ==== serial_lane_sample_packer_tb_top.sv ====
// self-checking bench for the lane sample packer
`timescale 1ns/1ps
module serial_lane_sample_packer_tb_top;
    import sample_packer_pkg::*;
    typedef logic [7:0] ptab_t [7];
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic [13:0] sampleEven;
    logic [13:0] sampleOdd;
    logic sampleValid = 1'b0;
    logic sampleReady;
    logic [7:0] lane [MAX_LANES];
    logic octetValid;
    logic frameStart;
    logic multiframeEnd;
    logic [3:0] frameLen = 4'h7;
    logic [55:0] laneBits [MAX_LANES];
    logic frameDone;
    int mfLen;
    int misalign;
    int beat = 0;
    int cycles = 0;
    int n_fail = 0;
    int num_checks = 0;

    always #20 ref_clk = ~ref_clk;

    function automatic logic [13:0] smp(input int i);
        return 14'(i * 157 + 677);
    endfunction

    function automatic logic [55:0] effBits(input int b);
        return {smp(b), smp(b + 1), smp(b + 2), smp(b + 3)};
    endfunction

    assign sampleEven = smp(2 * beat);
    assign sampleOdd = smp(2 * beat + 1);

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (sampleValid && sampleReady === 1'b1) beat <= beat + 1;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end

    serial_lane_sample_packer uut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrEn(regWrEn),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .sampleEven(sampleEven),
        .sampleOdd(sampleOdd),
        .sampleValid(sampleValid),
        .sampleReady(sampleReady),
        .firstLaneOctet(lane[0]),
        .secondLaneOctet(lane[1]),
        .thirdLaneOctet(lane[2]),
        .octetValid(octetValid),
        .frameStart(frameStart),
        .multiframeEnd(multiframeEnd)
    );

    lane_receiver_model rx (
        .ref_clk(ref_clk),
        .firstLane(lane[0]),
        .secondLane(lane[1]),
        .thirdLane(lane[2]),
        .octetValid(octetValid),
        .frameStart(frameStart),
        .multiframeEnd(multiframeEnd),
        .frameLen(frameLen),
        .laneBits(laneBits),
        .frameDone(frameDone),
        .mfLen(mfLen),
        .misalign(misalign)
    );

    task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkLane(input logic [55:0] got, input logic [55:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1; // one strobe per access
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic checkParams(input ptab_t t);
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            rd(ADDR_PARAM_F + 8'(i), d);
            chkReg(d, t[i]);
        end
    endtask

    task automatic waitFrame();
        int k;
        for (k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            #1;
            if (frameDone === 1'b1) break;
        end
        chkReg({7'h0, frameDone}, 8'h01);
    endtask

    task automatic startMode(input logic [1:0] m, input logic [3:0] f);
        wr(ADDR_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk);
        beat <= 0;
        frameLen <= f;
        wr(ADDR_CTRL, {5'h0, m, 1'b0});
    endtask

    task automatic testEff3();
        logic [7:0] d;
        rd(ADDR_CTRL, d);
        chkReg(d, 8'h00);
        rd(8'h40, d);
        chkReg(d, 8'h00);
        rd(ADDR_FRAMECNT, d);
        chkReg(d, 8'h00);
        rd(ADDR_STATUS, d);
        chkReg(d, 8'h00);
        checkParams('{8'h06, 8'h02, 8'h00, 8'h0d, 8'h0d, 8'h0b, 8'h02});
        wr(ADDR_PARAM_F, 8'h00);
        rd(ADDR_PARAM_F, d);
        chkReg(d, 8'h06);
        wr(ADDR_CTRL, 8'h01);
        waitFrame();
        for (int j = 0; j < 2; j++) begin
            waitFrame();
            for (int l = 0; l < 3; l++) begin
                chkLane(laneBits[l], effBits(12*j + 4*l));
            end
        end
        chkReg(8'(mfLen), 8'h03);
    endtask

    task automatic testEff2();
        startMode(2'b01, 4'h7);
        checkParams('{8'h06, 8'h01, 8'h00, 8'h0d, 8'h0d, 8'h07, 8'h02});
        wr(ADDR_CTRL, 8'h03);
        waitFrame();
        for (int j = 0; j < 2; j++) begin
            waitFrame();
            chkLane(laneBits[0], effBits(8 * j));
            chkLane(laneBits[1], effBits(8 * j + 4));
            chkLane(laneBits[2], 56'h0);
        end
    endtask

    task automatic testSimple();
        logic [7:0] d;
        startMode(2'b10, 4'h2);
        checkParams('{8'h01, 8'h01, 8'h01, 8'h0d, 8'h0f, 8'h00, 8'h08});
        wr(ADDR_PARAM_K, 8'h03);
        rd(ADDR_PARAM_K, d);
        chkReg(d, 8'h08);
        wr(ADDR_CTRL, 8'h05);
        waitFrame();
        for (int j = 0; j < 8; j++) begin
            waitFrame();
            chkLane(laneBits[0], {42'h0, smp(2*j), 2'b00});
            chkLane(laneBits[1], {42'h0, smp(2 * j + 1), 2'b00});
            chkLane(laneBits[2], 56'h0);
        end
        chkReg(8'(mfLen), 8'h09);
    endtask

    task automatic testUnderrun();
        logic [7:0] d;
        rd(ADDR_STATUS, d);
        chkReg(d, 8'h02);
        @(posedge ref_clk);
        sampleValid <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(ADDR_STATUS, d);
        chkReg(d, 8'h03);
        @(posedge ref_clk);
        sampleValid <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_STATUS, d);
        chkReg(d, 8'h02);
    endtask

    task automatic results();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        sampleValid <= 1'b1;
        testEff3();
        testEff2();
        testSimple();
        testUnderrun();
        chkReg(8'(misalign), 8'h00);
        results();
    end
endmodule
